//--- elps_regs.svh
`ifndef ELPS_REGS_SVH
`define ELPS_REGS_SVH
// register byte offsets (aligned words)
`define ELPS_OFF_CTRL     8'h00
`define ELPS_OFF_COUNTS   8'h04
`define ELPS_OFF_THRESH   8'h08
`define ELPS_OFF_MEMBERS  8'h0c
`define ELPS_OFF_STATUS   8'h10
`define ELPS_OFF_SYSADDR  8'h14
`define ELPS_OFF_EVCNT    8'h18
// ctrl fields
`define ELPS_CTRL_MODE_LO  0
`define ELPS_CTRL_L4_BIT   2
`define ELPS_CTRL_DYN_BIT  3
`define ELPS_CTRL_ACT_BIT  4
`define ELPS_CTRL_BIG_BIT  5
`define ELPS_CTRL_GRP_LO   8
// reset values
`define ELPS_CTRL_RST     32'h0000_0000
`define ELPS_COUNTS_RST   32'h0000_0101
`define ELPS_THRESH_RST   32'h0000_0000
`define ELPS_MEMBERS_RST  32'h0000_0001
`define ELPS_SYSADDR_RST  32'h0000_0000
// hash constants
`define ELPS_HASH_W       20
`define ELPS_MAX_LABELS   6
`define ELPS_NIB_V4       4'h4
`define ELPS_NIB_V6       4'h6
`define ELPS_HASH_SEED    20'h5a3c1
`define ELPS_HASH_MULT    20'h9e37b
`endif

//--- elps_pkg.sv
`default_nettype none
package elps_pkg;
  // label hashing mode
  typedef enum logic [1:0] {
    ELPS_LABEL_ONLY       = 2'h0,
    label_plus_ip_hash_mode_c = 2'h1,
    payload_address_hash_mode_c = 2'h2
  } elps_mode_e;
  // traffic class presented by the parser
  typedef enum logic [3:0] {
    ELPS_T_LABEL     = 4'h0,
    ELPS_T_BR_UCAST  = 4'h1,
    ELPS_T_BR_FLOOD  = 4'h2,
    ELPS_T_BR_MSNOOP = 4'h3,
    ELPS_T_P2P       = 4'h4,
    ELPS_T_IP_MCAST  = 4'h5,
    ELPS_T_IP_UCAST  = 4'h6
  } elps_traffic_e;
  // pipeline stage states, one-hot
  typedef enum logic [2:0] {
    ELPS_S_IDLE = 3'b001,
    ELPS_S_HASH = 3'b010,
    ELPS_S_OUT  = 3'b100
  } elps_state_e;
endpackage
`default_nettype wire

//--- elps_selector.sv
`include "elps_regs.svh"
`default_nettype none
module elps_selector
  import elps_pkg::*;
#(
  parameter int MAX_PATHS = 16,
  parameter int MAX_PORTS = 16
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // axi4-lite slave
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // packet descriptor from parser
  input  wire logic         pkt_valid,
  output logic              pkt_ready,
  input  wire logic [3:0]   pkt_type,
  input  wire logic [3:0]   pkt_label_count,
  input  wire logic [19:0]  pkt_labels [6],
  input  wire logic [3:0]   pkt_payload_nibble,
  input  wire logic [3:0]   pkt_in_port,
  input  wire logic [47:0]  pkt_mac_sa,
  input  wire logic [47:0]  pkt_mac_da,
  input  wire logic         pkt_is_ip,
  input  wire logic [127:0] pkt_ip_sa,
  input  wire logic [127:0] pkt_ip_da,
  input  wire logic         pkt_is_tcp_udp,
  input  wire logic [15:0]  pkt_l4_sp,
  input  wire logic [15:0]  pkt_l4_dp,
  input  wire logic         pkt_port_l4_en,
  input  wire logic         pkt_to_tunnel,
  input  wire logic         pkt_shared_queuing,
  input  wire logic [19:0]  pkt_service_id,
  input  wire logic [19:0]  pkt_mcast_id,
  // selection to egress
  output logic              sel_valid,
  input  wire logic         sel_ready,
  output logic [3:0]        sel_path,
  output logic [3:0]        sel_member,
  output logic              sel_is_group,
  output logic              sel_none,
  // group status
  output logic              grp_oper_up,
  output logic              grp_dyn_cost,
  output logic              cost_recalc
);

  localparam int HW = `ELPS_HASH_W;

  // deterministic mixing round
  function automatic logic [HW-1:0] mix(input logic [HW-1:0] acc, input logic [HW-1:0] d);
    logic [HW-1:0] t;
    t = acc ^ d;
    t = t ^ {t[12:0], t[19:13]};
    mix = t + `ELPS_HASH_MULT ^ {t[6:0], t[19:7]};
  endfunction

  // fold a 128-bit value into the hash
  function automatic logic [HW-1:0] fold128(input logic [HW-1:0] acc, input logic [127:0] v);
    logic [HW-1:0] a;
    a = acc;
    for (int i = 0; i < 6; i++) a = mix(a, v[i*20 +: 20]);
    fold128 = mix(a, {12'h000, v[127:120]});
  endfunction

  // remainder, with count one short-cut
  function automatic logic [3:0] pick(input logic [HW-1:0] h, input logic [4:0] n);
    logic [HW-1:0] r;
    r = '0;
    if (n > 5'h01) r = h % {15'h0000, n};
    pick = r[3:0];
  endfunction

  // configuration registers
  logic [31:0] ctrl_reg, counts_reg, thresh_reg, members_reg, sysaddr_reg;
  logic [15:0] evcnt_reg;

  wire elps_mode_e mode   = elps_mode_e'(ctrl_reg[`ELPS_CTRL_MODE_LO +: 2]);
  wire logic       l4_en  = ctrl_reg[`ELPS_CTRL_L4_BIT];
  wire logic       dyn_en = ctrl_reg[`ELPS_CTRL_DYN_BIT];
  wire logic       act_dc = ctrl_reg[`ELPS_CTRL_ACT_BIT];
  wire logic       big    = ctrl_reg[`ELPS_CTRL_BIG_BIT];
  wire logic [15:0] grp_mask = ctrl_reg[`ELPS_CTRL_GRP_LO +: 16];
  // route counts above sixteen saturate, so the path index always fits four bits
  wire logic [4:0] n_paths = (counts_reg[4:0] > 5'h10) ? 5'h10 : counts_reg[4:0];
  wire logic [3:0] thresh  = big ? thresh_reg[3:0] : {1'b0, thresh_reg[2:0]};

  // up-member count from member bitmap, a loop over entries
  logic [4:0] up_cnt;
  always_comb begin
    up_cnt = 5'h00;
    for (int i = 0; i < MAX_PORTS; i++) up_cnt = up_cnt + {4'h0, members_reg[i]};
  end

  // axi write path: address and data taken in either order
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;
  wire logic aw_now = aw_hold || (s_axi_awvalid && s_axi_awready);
  wire logic w_now  = w_hold || (s_axi_wvalid && s_axi_wready);
  wire logic [7:0]  wa = aw_hold ? aw_addr : s_axi_awaddr;
  wire logic [31:0] wd = w_hold ? w_data : s_axi_wdata;
  wire logic [3:0]  ws = w_hold ? w_strb : s_axi_wstrb;
  wire logic do_wr = aw_now && w_now && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) if (s[b]) o[b*8 +: 8] = n[b*8 +: 8];
    merge = o;
  endfunction

  // write handshake bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !do_wr) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // register writes; count fields keep five bits, the port count is informational only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg    <= `ELPS_CTRL_RST;
      counts_reg  <= `ELPS_COUNTS_RST;
      thresh_reg  <= `ELPS_THRESH_RST;
      members_reg <= `ELPS_MEMBERS_RST;
      sysaddr_reg <= `ELPS_SYSADDR_RST;
    end else if (do_wr) begin
      if (wa == `ELPS_OFF_CTRL) ctrl_reg <= merge(ctrl_reg, wd, ws);
      else if (wa == `ELPS_OFF_COUNTS) counts_reg <= merge(counts_reg, wd, ws) & 32'h0000_1f1f;
      else if (wa == `ELPS_OFF_THRESH) thresh_reg <= merge(thresh_reg, wd, ws) & 32'h0000_000f;
      else if (wa == `ELPS_OFF_MEMBERS) members_reg <= merge(members_reg, wd, ws) & 32'h0000_ffff;
      else if (wa == `ELPS_OFF_SYSADDR) sysaddr_reg <= merge(sysaddr_reg, wd, ws);
    end
  end

  // axi read path, one cycle answer
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp   = 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == `ELPS_OFF_CTRL) s_axi_rdata <= ctrl_reg;
      else if (s_axi_araddr == `ELPS_OFF_COUNTS) s_axi_rdata <= counts_reg;
      else if (s_axi_araddr == `ELPS_OFF_THRESH) s_axi_rdata <= thresh_reg;
      else if (s_axi_araddr == `ELPS_OFF_MEMBERS) s_axi_rdata <= members_reg;
      else if (s_axi_araddr == `ELPS_OFF_STATUS)
        s_axi_rdata <= {24'h000000, grp_dyn_cost, grp_oper_up, 1'b0, up_cnt};
      else if (s_axi_araddr == `ELPS_OFF_SYSADDR) s_axi_rdata <= sysaddr_reg;
      else if (s_axi_araddr == `ELPS_OFF_EVCNT) s_axi_rdata <= {16'h0000, evcnt_reg};
      else s_axi_rdata <= 32'h0000_0000; // unmapped reads as zero
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end

  // first hash round, combinational over the descriptor
  logic [HW-1:0] h_lbl, h_ip, h_mac, h_uc, h_first;
  logic          stat_path, stat_member;
  logic [HW-1:0] stat_key, mem_key;
  logic          is_ip_nib;
  always_comb begin
    // label stack over incoming port and system address; labels are 20-bit, no exp/ttl
    h_lbl = mix(`ELPS_HASH_SEED, {16'h0000, pkt_in_port});
    h_lbl = mix(h_lbl, sysaddr_reg[19:0] ^ {8'h00, sysaddr_reg[31:20]});
    for (int i = 0; i < `ELPS_MAX_LABELS; i++)
      if (i < pkt_label_count) h_lbl = mix(h_lbl, pkt_labels[i]);
    h_ip = fold128(`ELPS_HASH_SEED, pkt_ip_sa);
    h_ip = fold128(h_ip, pkt_ip_da);
    // bridged: mac first, ip replaces, ports if enabled at ingress
    h_mac = mix(mix(`ELPS_HASH_SEED, pkt_mac_sa[47:28]), mix(pkt_mac_sa[27:8], pkt_mac_da[47:28]));
    h_mac = mix(h_mac, {pkt_mac_sa[7:0], pkt_mac_da[27:16]});
    h_mac = mix(h_mac, {8'h00, pkt_mac_da[15:4]} ^ {16'h0000, pkt_mac_da[3:0]});
    h_uc  = pkt_is_ip ? h_ip : h_mac;
    if (pkt_port_l4_en && pkt_is_tcp_udp) h_uc = mix(h_uc, {4'h0, pkt_l4_sp} ^ {pkt_l4_dp, 4'h0});
    is_ip_nib = (pkt_payload_nibble == `ELPS_NIB_V4) || (pkt_payload_nibble == `ELPS_NIB_V6);
    stat_path   = 1'b0;
    stat_member = 1'b0;
    stat_key    = pkt_service_id;
    mem_key     = '0;
    h_first     = h_lbl;
    case (elps_traffic_e'(pkt_type))
      ELPS_T_LABEL: begin
        // ip-aware modes fall back beyond six labels or on a non-ip nibble
        if (mode != ELPS_LABEL_ONLY && is_ip_nib &&
            pkt_label_count <= 4'(`ELPS_MAX_LABELS)) begin
          if (mode == payload_address_hash_mode_c) h_first = h_ip;
          else h_first = fold128(fold128(h_lbl, pkt_ip_sa), pkt_ip_da);
        end
      end
      ELPS_T_BR_UCAST: h_first = h_uc;
      ELPS_T_BR_FLOOD: begin
        stat_path   = 1'b1;
        stat_member = !pkt_to_tunnel;
        h_first     = h_uc;
      end
      ELPS_T_BR_MSNOOP: begin
        stat_path   = 1'b1;
        stat_member = 1'b1;
        mem_key     = pkt_mcast_id;
      end
      ELPS_T_P2P: begin
        stat_path   = !pkt_shared_queuing;
        stat_member = !pkt_shared_queuing;
        h_first     = h_uc;
      end
      ELPS_T_IP_MCAST: begin
        stat_member = 1'b1;
        mem_key     = pkt_mcast_id;
        h_first     = h_ip; // udp ports are not folded in
      end
      ELPS_T_IP_UCAST: begin
        h_first = h_ip;
        if (l4_en && pkt_is_tcp_udp) h_first = mix(h_ip, {4'h0, pkt_l4_sp} ^ {pkt_l4_dp, 4'h0});
      end
      default: h_first = h_lbl;
    endcase
    if (stat_member && pkt_type != ELPS_T_BR_MSNOOP && pkt_type != ELPS_T_IP_MCAST)
      mem_key = pkt_service_id;
  end

  // single register stage; a held result stalls the parser
  logic [HW-1:0] h1_reg, mkey_reg, skey_reg;
  logic          spath_reg, smem_reg;
  elps_state_e   st_reg;
  assign pkt_ready = (st_reg != ELPS_S_OUT) || sel_ready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg    <= ELPS_S_IDLE;
      h1_reg    <= '0;
      mkey_reg  <= '0;
      skey_reg  <= '0;
      spath_reg <= 1'b0;
      smem_reg  <= 1'b0;
    end else if (pkt_valid && pkt_ready) begin
      st_reg    <= ELPS_S_OUT;
      h1_reg    <= h_first;
      mkey_reg  <= mem_key;
      skey_reg  <= stat_key;
      spath_reg <= stat_path;
      smem_reg  <= stat_member;
    end else if (sel_ready) st_reg <= ELPS_S_IDLE;
  end
  assign sel_valid = (st_reg == ELPS_S_OUT);

  // second round uses the live member count, so changes apply at once
  logic [3:0] path_c, mem_c;
  logic [HW-1:0] h2;
  always_comb begin
    path_c = pick(spath_reg ? skey_reg : h1_reg, n_paths);
    h2     = mix(h1_reg, `ELPS_HASH_SEED);
    mem_c  = pick(smem_reg ? mkey_reg : h2, up_cnt);
  end
  assign sel_path     = path_c;
  assign sel_is_group = grp_mask[path_c];
  assign sel_member   = sel_is_group ? mem_c : 4'h0;
  assign sel_none     = sel_is_group && (up_cnt == 5'h00);

  // threshold actions and cost events
  logic [4:0] up_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grp_oper_up  <= 1'b0;
      grp_dyn_cost <= 1'b0;
      cost_recalc  <= 1'b0;
      up_prev      <= 5'h00;
      evcnt_reg    <= 16'h0000;
    end else begin
      up_prev      <= up_cnt;
      grp_oper_up  <= act_dc || (up_cnt >= {1'b0, thresh});
      grp_dyn_cost <= act_dc && (up_cnt < {1'b0, thresh});
      cost_recalc  <= dyn_en && (up_cnt > {1'b0, thresh}) && (up_cnt != up_prev);
      if (dyn_en && (up_cnt > {1'b0, thresh}) && (up_cnt != up_prev))
        evcnt_reg <= evcnt_reg + 16'h0001;
    end
  end

  // checks
  property p_path_range;
    @(posedge aclk) disable iff (!aresetn)
      sel_valid && n_paths != 5'h00 |-> {1'b0, sel_path} < n_paths;
  endproperty
  a_path_range: assert property (p_path_range) else $error("path beyond route count");
  property p_single;
    @(posedge aclk) disable iff (!aresetn)
      sel_valid && n_paths == 5'h01 |-> sel_path == 4'h0;
  endproperty
  a_single: assert property (p_single) else $error("single route not zero");
  property p_member_range;
    @(posedge aclk) disable iff (!aresetn)
      sel_valid && sel_is_group && up_cnt != 5'h00 |-> {1'b0, sel_member} < up_cnt;
  endproperty
  a_member_range: assert property (p_member_range) else $error("member beyond count");
  property p_none;
    @(posedge aclk) disable iff (!aresetn)
      sel_valid && sel_is_group && up_cnt == 5'h00 |-> sel_none;
  endproperty
  a_none: assert property (p_none) else $error("empty group gave selection");
  property p_down;
    @(posedge aclk) disable iff (!aresetn)
      !act_dc && up_cnt < {1'b0, thresh} ##1 $stable(ctrl_reg) |-> !grp_oper_up;
  endproperty
  a_down: assert property (p_down) else $error("group up below threshold");
  property p_dyn;
    @(posedge aclk) disable iff (!aresetn)
      act_dc && up_cnt < {1'b0, thresh} ##1 $stable(ctrl_reg) |-> grp_dyn_cost;
  endproperty
  a_dyn: assert property (p_dyn) else $error("dynamic cost flag missing");
  property p_recalc;
    @(posedge aclk) disable iff (!aresetn)
      cost_recalc |-> $past(dyn_en) && $past(up_cnt) != $past(up_prev);
  endproperty
  a_recalc: assert property (p_recalc) else $error("spurious cost event");
  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
      sel_valid && !sel_ready |=> sel_valid && $stable(h1_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("selection dropped while stalled");
endmodule // elps_selector
`default_nettype wire

//--- elps_egress_model.sv
`default_nettype none
module elps_egress_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // selection from the block
  input  wire logic       sel_valid,
  input  wire logic [3:0] sel_path,
  input  wire logic [3:0] sel_member,
  input  wire logic       sel_is_group,
  input  wire logic       sel_none,
  output logic            sel_ready,
  // bench side
  input  wire logic       slow,
  output logic            got,
  output logic [9:0]      got_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  // egress drains at once, or only every other cycle to exercise back-pressure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_ready <= 1'b0;
    end else begin
      sel_ready <= slow ? ~sel_ready : 1'b1;
    end
  end

  // fields are live combinational outputs, so latch them at the taking edge only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      got <= 1'b0;
    end else begin
      got <= sel_valid & sel_ready;
      if (sel_valid && sel_ready) begin
        got_sel <= {sel_none, sel_is_group, sel_path, sel_member};
      end
    end
  end
endmodule // elps_egress_model
`default_nettype wire

//--- elps_selector_tb.sv
`include "elps_regs.svh"
`default_nettype none
module elps_selector_tb
  import elps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int t, m, tun, ip, l4, sq, nib, cnt, vary, keep;} elps_case_s;
  // wiring
  logic         aclk, aresetn, pkt_valid, pkt_ready, sel_valid, sel_ready, sel_is_group;
  logic         sel_none, grp_oper_up, grp_dyn_cost, cost_recalc, slow, got;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic         pkt_is_ip, pkt_is_tcp_udp, pkt_port_l4_en, pkt_to_tunnel, pkt_shared_queuing;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [3:0]   s_axi_wstrb, pkt_type, pkt_label_count, pkt_payload_nibble, pkt_in_port;
  logic [3:0]   sel_path, sel_member;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [9:0]   got_sel, a, b;
  logic [15:0]  pkt_l4_sp, pkt_l4_dp, grp_mask;
  logic [19:0]  pkt_service_id, pkt_mcast_id;
  logic [19:0]  pkt_labels [6];
  logic [31:0]  s_axi_wdata, s_axi_rdata, q, e0;
  logic [47:0]  pkt_mac_sa, pkt_mac_da;
  logic [127:0] pkt_ip_sa, pkt_ip_da;
  int           seed = 32'h5386ccdd;
  int           mismatches = 0, checked = 0, pulses = 0, routes = 1, ups = 1;
  logic [7:0]   offs [7] = '{`ELPS_OFF_CTRL, `ELPS_OFF_COUNTS, `ELPS_OFF_THRESH,
                             `ELPS_OFF_MEMBERS, `ELPS_OFF_STATUS, `ELPS_OFF_EVCNT, 8'h20};
  logic [31:0]  rstv [7] = '{`ELPS_CTRL_RST, `ELPS_COUNTS_RST, `ELPS_THRESH_RST,
                             `ELPS_MEMBERS_RST, 32'h41, 32'h0, 32'h0};
  // ctrl, threshold, member bitmap, status {dyn, up, 0, count}
  int           thr [6][4] = '{'{0, 4, 'h7, 'h03}, '{0, 4, 'hf, 'h44},
                               '{'h20, 15, 'h7fff, 'h4f}, '{'h20, 15, 'h3fff, 'h0e},
                               '{'h10, 4, 'h7, 'h83}, '{'h10, 4, 'hf, 'h04}};
  int           cfg_r [4] = '{1, 16, 5, 16};
  logic [15:0]  cfg_m [4] = '{16'h0001, 16'hffff, 16'h0a51, 16'h0000};
  // type, mode, tunnel, ip, l4 enable, shared queuing, nibble, labels, varied, kept bits
  elps_case_s   cases [12] = '{
    '{2, 0, 0, 1, 1, 0, 4, 2, 'h1f, 'h3ff}, '{2, 0, 1, 1, 1, 0, 4, 2, 'h03, 'h3f0},
    '{3, 0, 0, 1, 1, 0, 4, 2, 'h1f, 'h30f}, '{4, 0, 0, 1, 1, 0, 4, 2, 'h1f, 'h3ff},
    '{4, 0, 0, 1, 0, 1, 4, 2, 'h40, 'h3ff}, '{5, 0, 0, 1, 1, 0, 4, 2, 'h04, 'h3ff},
    '{6, 0, 0, 1, 1, 0, 4, 2, 'h4d, 'h3ff}, '{1, 0, 0, 1, 0, 0, 4, 2, 'h45, 'h3ff},
    '{0, 0, 0, 0, 1, 0, 5, 3, 'h27, 'h3ff}, '{0, 1, 0, 0, 1, 0, 5, 3, 'h02, 'h3ff},
    '{0, 1, 0, 0, 1, 0, 4, 7, 'h02, 'h3ff}, '{0, 2, 0, 0, 1, 0, 4, 3, 'h18, 'h3ff}};

  elps_selector DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pkt_valid, .pkt_ready, .pkt_type, .pkt_label_count, .pkt_labels, .pkt_payload_nibble,
    .pkt_in_port, .pkt_mac_sa, .pkt_mac_da, .pkt_is_ip, .pkt_ip_sa, .pkt_ip_da, .pkt_is_tcp_udp,
    .pkt_l4_sp, .pkt_l4_dp, .pkt_port_l4_en, .pkt_to_tunnel, .pkt_shared_queuing,
    .pkt_service_id, .pkt_mcast_id, .sel_valid, .sel_ready, .sel_path, .sel_member,
    .sel_is_group, .sel_none, .grp_oper_up, .grp_dyn_cost, .cost_recalc);
  elps_egress_model egress (.aclk, .aresetn, .sel_valid, .sel_path, .sel_member, .sel_is_group,
    .sel_none, .sel_ready, .slow, .got, .got_sel);

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // count cost events away from the edge that launches them
  always @(negedge aclk) pulses += int'(cost_recalc);

  function automatic logic [31:0] r32();
    return $random(seed);
  endfunction
  // range model: path below route count, member below up count, none only for an empty group
  function automatic logic [9:0] model_sel(input logic [9:0] g);
    logic grp;
    grp = grp_mask[g[7:4]];
    return {grp && ups == 0, grp, 4'(int'(g[7:4]) % routes),
            (grp && ups != 0) ? 4'(int'(g[3:0]) % ups) : 4'h0};
  endfunction
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tmo(input bit bad);
    if (bad) begin
      mismatches++;
      $display("unexpected hang at %0t: exp %h got %h", $time, 1'b1, 1'b0);
      results();
    end
  endtask
  task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected word at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_sel(input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected selection at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bit ah, wh, bh;
    int n;
    bh = 0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bh && n < 100) begin
      @(negedge aclk);
      ah = s_axi_awready;
      wh = s_axi_wready;
      bh = s_axi_bvalid;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    tmo(n >= 100);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] r);
    bit ah, h;
    int n;
    h = 0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!h && n < 100) begin
      @(negedge aclk);
      ah = s_axi_arready;
      h = s_axi_rvalid;
      r = s_axi_rdata;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    tmo(n >= 100);
  endtask
  // one descriptor in, one selection out through the egress model
  task automatic send(output logic [9:0] r);
    bit ah, h;
    int n;
    h = 0;
    n = 0;
    @(posedge aclk);
    pkt_valid <= 1'b1;
    while (!h && n < 100) begin
      @(negedge aclk);
      ah = pkt_ready;
      h = got;
      @(posedge aclk);
      if (ah) pkt_valid <= 1'b0;
      n++;
    end
    r = got_sel;
    tmo(n >= 100);
  endtask
  task automatic vary(input int k);
    @(posedge aclk);
    case (k)
      0: pkt_mac_sa <= {r32(), 16'(r32())};
      1: pkt_ip_sa <= {r32(), r32(), r32(), r32()};
      2: pkt_l4_sp <= 16'(r32());
      3: for (int i = 0; i < 6; i++) pkt_labels[i] <= 20'(r32());
      4: pkt_in_port <= pkt_in_port + 4'h1;
      5: pkt_payload_nibble <= pkt_payload_nibble ^ 4'h2;
      default: pkt_service_id <= pkt_service_id + 20'h1;
    endcase
  endtask
  task automatic rnd_pkt(input elps_case_s c);
    for (int k = 0; k < 5; k++) vary(k);
    @(posedge aclk);
    {pkt_type, pkt_payload_nibble, pkt_label_count} <= {4'(c.t), 4'(c.nib), 4'(c.cnt)};
    {pkt_to_tunnel, pkt_is_ip, pkt_port_l4_en} <= {1'(c.tun), 1'(c.ip), 1'(c.l4)};
    {pkt_shared_queuing, pkt_is_tcp_udp} <= {1'(c.sq), 1'b1};
    {pkt_mac_da, pkt_l4_dp} <= {r32(), r32()};
    pkt_ip_da <= {r32(), r32(), r32(), r32()};
    {pkt_service_id, pkt_mcast_id} <= {20'(r32()), 20'(r32())};
  endtask

  initial begin
    {aresetn, pkt_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, slow, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {pkt_type, pkt_label_count, pkt_payload_nibble, pkt_in_port, pkt_mac_sa, pkt_mac_da} = '0;
    {pkt_is_ip, pkt_ip_sa, pkt_ip_da, pkt_is_tcp_udp, pkt_l4_sp, pkt_l4_dp} = '0;
    {pkt_port_l4_en, pkt_to_tunnel, pkt_shared_queuing, pkt_service_id, pkt_mcast_id} = '0;
    pkt_labels = '{default: 20'h0};
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, read-only status, unmapped word, read-back
    wr(`ELPS_OFF_STATUS, 32'hffffffff);
    wr(8'h20, 32'hffffffff);
    foreach (offs[i]) begin
      rd(offs[i], q);
      cmp_reg(rstv[i], q);
    end
    e0 = r32();
    wr(`ELPS_OFF_SYSADDR, e0);
    rd(`ELPS_OFF_SYSADDR, q);
    cmp_reg(e0, q);
    wr(`ELPS_OFF_CTRL, 32'h00a5a52d);
    rd(`ELPS_OFF_CTRL, q);
    cmp_reg(32'h00a5a52d, q);
    $display("register test done");
    // threshold actions; dynamic-cost rows do not judge the up flag
    foreach (thr[i]) begin
      wr(`ELPS_OFF_CTRL, 32'(thr[i][0]));
      wr(`ELPS_OFF_THRESH, 32'(thr[i][1]));
      wr(`ELPS_OFF_MEMBERS, 32'(thr[i][2]));
      rd(`ELPS_OFF_STATUS, q);
      e0 = thr[i][0][4] ? 32'hbf : 32'hff;
      cmp_reg(32'(thr[i][3]) & e0, q & e0);
      @(negedge aclk);
      cmp_reg(32'(thr[i][3]) & e0 & 32'hc0, {24'h0, grp_dyn_cost, grp_oper_up, 6'h0} & e0);
    end
    $display("threshold test done");
    // global dynamic cost above threshold: one event per change of up count
    wr(`ELPS_OFF_CTRL, 32'h08);
    wr(`ELPS_OFF_THRESH, 32'h2);
    wr(`ELPS_OFF_MEMBERS, 32'h7);
    rd(`ELPS_OFF_EVCNT, e0);
    pulses = 0;
    wr(`ELPS_OFF_MEMBERS, 32'hf);
    wr(`ELPS_OFF_MEMBERS, 32'h1f);
    rd(`ELPS_OFF_EVCNT, q);
    cmp_reg(e0 + 32'h2, q);
    cmp_reg(32'h2, 32'(pulses));
    $display("cost event test done");
    // route and member counts, each flow sent twice, egress stalling on odd rounds
    grp_mask = 16'h00ff;
    wr(`ELPS_OFF_CTRL, 32'h0000ff00);
    foreach (cfg_r[i]) begin
      routes = cfg_r[i];
      ups = $countones(cfg_m[i]);
      slow <= i[0];
      wr(`ELPS_OFF_COUNTS, 32'h100 | 32'(routes));
      wr(`ELPS_OFF_MEMBERS, {16'h0, cfg_m[i]});
      repeat (6) begin
        rnd_pkt('{6, 0, 0, 1, 1, 0, 4, 2, 0, 0});
        send(a);
        cmp_sel(model_sel(a), a);
        send(b);
        cmp_sel(a, b);
      end
    end
    $display("count test done");
    // fields outside each traffic type's key must not move the selection
    grp_mask = 16'hffff;
    ups = 16;
    wr(`ELPS_OFF_MEMBERS, 32'hffff);
    foreach (cases[i]) begin
      slow <= i[0];
      wr(`ELPS_OFF_CTRL, 32'h00ffff00 | 32'(cases[i].m));
      rnd_pkt(cases[i]);
      send(a);
      cmp_sel(model_sel(a), a);
      repeat (2) begin
        for (int k = 0; k < 7; k++) if (cases[i].vary[k]) vary(k);
        send(b);
        cmp_sel(a & 10'(cases[i].keep), b & 10'(cases[i].keep));
      end
    end
    $display("traffic type test done");
    results();
  end
endmodule // elps_selector_tb
`default_nettype wire
